// [sfms_core.sv]
// Mode-switch logic of a quad-capable serial flash: four-wire instruction mode,
// continuous read, 4-byte addressing, status register 1 write enables and soft reset.
// Assumes the host link runs far slower than clk; all link pins are resynchronised.
// Notes on behaviour
// - QPI exit field reads 1001b; FFh or soft reset leaves QPI.
// - Instruction 38h enters QPI only with quad enable set; entry field 00001b.
// - Continuous read is supported and advertised by bit 09.
// - Mode byte 00h ends continuous read when the current read finishes.
// - Fh on all lanes for 8 or 10 clocks ends continuous read.
// - Mode byte Axh with quad enable set enters continuous read; field 1101b.
// - Quad enable field bits 22:20 reads 100b; bit sits in status register 2.
// - Hold/reset disable bit 23 reads 0b.
// - 06h enables non-volatile SR1 write, 50h volatile override; field 1101001b.
// - 66h then 99h clears QPI, continuous read and write enables, reloads SR1 from its non-volatile copy and restores the power-up address mode.
// - E9h leaves 4-byte mode; exit field 15:14 reads 01b.
// - B7h enters 4-byte mode without write enable; advertised support.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sfms_core #(
   parameter bit         ADDR4_AT_POWERUP   = 1'b0,
   parameter bit         QUAD_EN_AT_POWERUP = 1'b0,
   parameter logic [7:0] SR1_AT_POWERUP     = 8'h00
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        link_sclk,
   input  wire logic        link_cs_n,
   input  wire logic [3:0]  four_data_lines_in,
   output logic      [3:0]  four_data_lines_out,
   output logic      [3:0]  four_data_lines_oe_n,
   output logic             qpi_mode,
   output logic             cont_read,
   output logic             four_byte_mode,
   output logic             quad_lane_enable_bit
);
   import sfms_pkg::*;

   logic [2:0] sclk_sync;
   logic [2:0] cs_sync;
   logic [3:0] io_meta;
   logic [3:0] io_s;
   logic       sclk_rise;
   logic       frame_start;
   logic       frame_end;
   logic       cs_low;

   logic [7:0]  clk_cnt_reg;
   logic [7:0]  nbits_reg;
   logic [15:0] shift_reg;
   logic        quad_frame_reg;
   logic        read_frame_reg;
   logic        cont_start_reg;
   logic [7:0]  mode_byte_reg;
   logic        mode_seen_reg;
   logic        ff_run_reg;
   logic [7:0]  ff_cnt_reg;

   logic        qpi_reg;
   logic        cont_reg;
   logic        addr4_reg;
   logic        quad_en_reg;
   logic        wel_reg;
   logic        vol_wen_reg;
   logic        vol_act_reg;
   logic        rst_arm_reg;
   logic [7:0]  sr1_nv_reg;
   logic [7:0]  sr1_vol_reg;

   logic [7:0]  mode_pos;
   logic [7:0]  ins;
   logic [7:0]  ins_data;
   logic        cmd8;
   logic        cmd16;
   logic        soft_rst;
   logic        ctrl_wr;

   // Array reads are outside this block, so the data lanes are never driven.
   assign four_data_lines_out  = 4'h0;
   assign four_data_lines_oe_n = 4'hF;
   assign qpi_mode             = qpi_reg;
   assign cont_read            = cont_reg;
   assign four_byte_mode       = addr4_reg;
   assign quad_lane_enable_bit = quad_en_reg;

   // Two flops before any logic; the third stage only serves edge detection.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         io_meta   <= 4'h0;
         io_s      <= 4'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], link_sclk};
         cs_sync   <= {cs_sync[1:0], link_cs_n};
         io_meta   <= four_data_lines_in;
         io_s      <= io_meta;
      end
   end

   assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
   assign cs_low      = ~cs_sync[1];
   assign frame_start = cs_sync[2] & ~cs_sync[1];
   assign frame_end   = ~cs_sync[2] & cs_sync[1];

   // In a continuous-read frame the address starts at once; otherwise after the opcode.
   assign mode_pos = (cont_start_reg ? 8'h00 : (qpi_reg ? CLK_INS_QPI : CLK_INS_SPI))
                   + (addr4_reg ? NIB_ADDR_4B : NIB_ADDR_3B);

   // Frame shifter: one bit per clock in single-lane phases, a nibble in quad phases.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_cnt_reg    <= 8'h00;
         nbits_reg      <= 8'h00;
         shift_reg      <= 16'h0000;
         quad_frame_reg <= 1'b0;
         read_frame_reg <= 1'b0;
         cont_start_reg <= 1'b0;
         mode_byte_reg  <= 8'h00;
         mode_seen_reg  <= 1'b0;
         ff_run_reg     <= 1'b0;
         ff_cnt_reg     <= 8'h00;
      end else if (frame_start) begin
         clk_cnt_reg    <= 8'h00;
         nbits_reg      <= 8'h00;
         shift_reg      <= 16'h0000;
         quad_frame_reg <= qpi_reg | cont_reg;
         read_frame_reg <= cont_reg;
         cont_start_reg <= cont_reg;
         mode_seen_reg  <= 1'b0;
         ff_run_reg     <= 1'b1;
         ff_cnt_reg     <= 8'h00;
      end else if (sclk_rise && cs_low) begin
         if (clk_cnt_reg != 8'hFF) begin
            clk_cnt_reg <= clk_cnt_reg + 8'h01;
         end
         if (quad_frame_reg) begin
            shift_reg <= {shift_reg[11:0], io_s};
            if (nbits_reg < 8'hF0) begin
               nbits_reg <= nbits_reg + 8'h04;
            end
            if (qpi_reg && !read_frame_reg && nbits_reg == 8'h04
                && {shift_reg[3:0], io_s} == INS_QUAD_READ) begin
               read_frame_reg <= 1'b1;
            end
         end else begin
            shift_reg <= {shift_reg[14:0], io_s[0]};
            if (nbits_reg != 8'hFF) begin
               nbits_reg <= nbits_reg + 8'h01;
            end
            if (nbits_reg == 8'h07 && {shift_reg[6:0], io_s[0]} == INS_QUAD_READ) begin
               read_frame_reg <= 1'b1;
               quad_frame_reg <= 1'b1;
            end
         end
         if (read_frame_reg && clk_cnt_reg == mode_pos) begin
            mode_byte_reg[7:4] <= io_s;
         end
         if (read_frame_reg && clk_cnt_reg == mode_pos + 8'h01) begin
            mode_byte_reg[3:0] <= io_s;
            mode_seen_reg      <= 1'b1;
         end
         if (io_s != 4'hF) begin
            ff_run_reg <= 1'b0;
         end else if (ff_run_reg && ff_cnt_reg != 8'hFF) begin
            ff_cnt_reg <= ff_cnt_reg + 8'h01;
         end
      end
   end

   // A command counts only when the frame held exactly one or two whole bytes.
   assign ins      = (nbits_reg == 8'h10) ? shift_reg[15:8] : shift_reg[7:0];
   assign ins_data = shift_reg[7:0];
   assign cmd8     = frame_end && !read_frame_reg && nbits_reg == 8'h08;
   assign cmd16    = frame_end && !read_frame_reg && nbits_reg == 8'h10;
   assign soft_rst = cmd8 && ins == INS_RST && rst_arm_reg;
   assign ctrl_wr  = reg_wr && reg_addr == ADDR_CTRL;

   // Reset-enable stays armed for exactly one following frame.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rst_arm_reg <= 1'b0;
      end else if (frame_end) begin
         rst_arm_reg <= cmd8 && ins == INS_RST_EN;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         qpi_reg <= 1'b0;
      end else if (soft_rst) begin
         qpi_reg <= 1'b0;
      end else if (cmd8 && ins == INS_QPI_EXIT && qpi_reg) begin
         qpi_reg <= 1'b0;
      end else if (cmd8 && ins == INS_QPI_ENTER && quad_en_reg) begin
         qpi_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr4_reg <= ADDR4_AT_POWERUP;
      end else if (soft_rst) begin
         addr4_reg <= ADDR4_AT_POWERUP;
      end else if (cmd8 && ins == INS_4B_EXIT) begin
         addr4_reg <= 1'b0;
      end else if (cmd8 && ins == INS_4B_ENTER) begin
         addr4_reg <= 1'b1;
      end
   end

   // The mode byte decides at the end of each read whether the next frame skips the opcode.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cont_reg <= 1'b0;
      end else if (soft_rst) begin
         cont_reg <= 1'b0;
      end else if (frame_end && cont_start_reg
                   && ff_cnt_reg >= (addr4_reg ? CLK_FF_4B : CLK_FF_3B)) begin
         cont_reg <= 1'b0;
      end else if (frame_end && read_frame_reg && mode_seen_reg) begin
         if (mode_byte_reg == MODE_EXIT) begin
            cont_reg <= 1'b0;
         end else begin
            cont_reg <= mode_byte_reg[7:4] == MODE_ENTRY_HI && quad_en_reg;
         end
      end
   end

   // Write enables: 06h for the non-volatile copy, 50h for the volatile override.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wel_reg     <= 1'b0;
         vol_wen_reg <= 1'b0;
      end else if (soft_rst || cmd16) begin
         wel_reg     <= 1'b0;
         vol_wen_reg <= 1'b0;
      end else if (cmd8 && ins == INS_WREN) begin
         wel_reg <= 1'b1;
      end else if (cmd8 && ins == INS_VOL_WREN) begin
         vol_wen_reg <= 1'b1;
      end
   end

   // Status register 1 powers up from its non-volatile copy.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sr1_nv_reg  <= SR1_AT_POWERUP;
         sr1_vol_reg <= SR1_AT_POWERUP;
         vol_act_reg <= 1'b0;
      end else if (soft_rst) begin
         sr1_vol_reg <= sr1_nv_reg;
         vol_act_reg <= 1'b0;
      end else if (cmd16 && ins == INS_WR_SR1) begin
         if (vol_wen_reg) begin
            sr1_vol_reg <= ins_data;
            vol_act_reg <= 1'b1;
         end else if (wel_reg) begin
            sr1_nv_reg  <= ins_data;
            sr1_vol_reg <= ins_data;
         end
      end
   end

   // Quad enable lives in status register 2; software may also preset it.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         quad_en_reg <= QUAD_EN_AT_POWERUP;
      end else if (ctrl_wr) begin
         quad_en_reg <= reg_wdata[0];
      end else if (cmd16 && ins == INS_WR_SR2 && (wel_reg || vol_wen_reg)) begin
         quad_en_reg <= ins_data[QUAD_EN_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL:   reg_rdata <= {31'h0000_0000, quad_en_reg};
            ADDR_STAT: begin
               reg_rdata                <= 32'h0000_0000;
               reg_rdata[ST_QPI]        <= qpi_reg;
               reg_rdata[ST_CONT]       <= cont_reg;
               reg_rdata[ST_4B]         <= addr4_reg;
               reg_rdata[ST_WEL]        <= wel_reg;
               reg_rdata[ST_VOL_WEN]    <= vol_wen_reg;
               reg_rdata[ST_VOL_ACT]    <= vol_act_reg;
               reg_rdata[ST_RST_ARM]    <= rst_arm_reg;
               reg_rdata[ST_QUAD_EN]    <= quad_en_reg;
               reg_rdata[ST_SR1_LSB+:8] <= sr1_vol_reg;
            end
            ADDR_PDW_68: reg_rdata <= PDW_68;
            ADDR_PDW_6C: reg_rdata <= PDW_6C;
            default:     reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // sfms_core
`default_nettype wire

// [sfms_pkg.sv]
// Constants for the serial flash mode-switch block: register map, advertised
// parameter dwords, instruction codes and link phase counts.
// Assumes a plain register port with byte addresses and 32-bit data.
`default_nettype none
package sfms_pkg;

   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_PDW_68 = 8'h68;
   localparam logic [7:0] ADDR_PDW_6C = 8'h6C;

   // Advertised fields of the dword at 68h, low field first.
   localparam logic [3:0] PF_QPI_EXIT     = 4'h9;   // 1001b
   localparam logic [4:0] PF_QPI_ENTRY    = 5'h01;  // 00001b
   localparam logic       PF_CONT_SUPP    = 1'b1;
   localparam logic [5:0] PF_CONT_EXIT    = 6'h3D;  // 111101b
   localparam logic [3:0] PF_CONT_ENTRY   = 4'hD;   // 1101b
   localparam logic [2:0] PF_QUAD_EN_REQ  = 3'h4;   // 100b
   localparam logic       PF_HOLD_RST_DIS = 1'b0;
   localparam logic [7:0] PF_RSVD_68      = 8'hFF;
   localparam logic [31:0] PDW_68 = {PF_RSVD_68, PF_HOLD_RST_DIS, PF_QUAD_EN_REQ, PF_CONT_ENTRY,
                                     PF_CONT_EXIT, PF_CONT_SUPP, PF_QPI_ENTRY, PF_QPI_EXIT};

   // Advertised fields of the dword at 6Ch, low field first.
   localparam logic [6:0] PF_SR1_KIND     = 7'h69;  // 1101001b
   localparam logic       PF_RSVD_6C      = 1'b1;
   localparam logic [5:0] PF_SOFT_RESET   = 6'h10;  // 010000b
   localparam logic [1:0] PF_EXIT_4B      = 2'h1;   // 01b
   localparam logic [7:0] PF_EXIT_4B_HI   = 8'hF9;
   localparam logic [7:0] PF_ENTER_4B     = 8'h85;
   localparam logic [31:0] PDW_6C = {PF_ENTER_4B, PF_EXIT_4B_HI, PF_EXIT_4B,
                                     PF_SOFT_RESET, PF_RSVD_6C, PF_SR1_KIND};

   // Instruction codes.
   localparam logic [7:0] INS_WREN      = 8'h06;
   localparam logic [7:0] INS_VOL_WREN  = 8'h50;
   localparam logic [7:0] INS_WR_SR1    = 8'h01;
   localparam logic [7:0] INS_WR_SR2    = 8'h31;
   localparam logic [7:0] INS_QPI_ENTER = 8'h38;
   localparam logic [7:0] INS_QPI_EXIT  = 8'hFF;
   localparam logic [7:0] INS_RST_EN    = 8'h66;
   localparam logic [7:0] INS_RST       = 8'h99;
   localparam logic [7:0] INS_4B_ENTER  = 8'hB7;
   localparam logic [7:0] INS_4B_EXIT   = 8'hE9;
   localparam logic [7:0] INS_QUAD_READ = 8'hEB;

   // Continuous-read mode byte values and phase lengths in link clocks.
   localparam logic [7:0] MODE_EXIT      = 8'h00;
   localparam logic [3:0] MODE_ENTRY_HI  = 4'hA;
   localparam logic [7:0] NIB_ADDR_3B    = 8'h06;
   localparam logic [7:0] NIB_ADDR_4B    = 8'h08;
   localparam logic [7:0] CLK_INS_SPI    = 8'h08;
   localparam logic [7:0] CLK_INS_QPI    = 8'h02;
   localparam logic [7:0] CLK_FF_3B      = 8'h08;
   localparam logic [7:0] CLK_FF_4B      = 8'h0A;
   localparam int         QUAD_EN_BIT    = 1;

   // Status register bit positions.
   localparam int ST_QPI      = 0;
   localparam int ST_CONT     = 1;
   localparam int ST_4B       = 2;
   localparam int ST_WEL      = 3;
   localparam int ST_VOL_WEN  = 4;
   localparam int ST_VOL_ACT  = 5;
   localparam int ST_RST_ARM  = 6;
   localparam int ST_QUAD_EN  = 7;
   localparam int ST_SR1_LSB  = 8;

endpackage
`default_nettype wire

// [sfms_assertions.sv]
// Checker for the flash mode-switch block, watching only its top ports.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sfms_assertions
   import sfms_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        link_sclk,
   input wire logic        link_cs_n,
   input wire logic [3:0]  four_data_lines_in,
   input wire logic [3:0]  four_data_lines_out,
   input wire logic [3:0]  four_data_lines_oe_n,
   input wire logic        qpi_mode,
   input wire logic        cont_read,
   input wire logic        four_byte_mode,
   input wire logic        quad_lane_enable_bit
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   pdw68_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h68 |->
      reg_rdata == 32'hFF4DF619) else $error("parameter dword 68h wrong");
   pdw6c_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h6C |->
      reg_rdata == 32'h85F950E9) else $error("parameter dword 6Ch wrong");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   qpi_quad_a: assert property ($rose(qpi_mode) |-> quad_lane_enable_bit)
      else $error("four-wire mode entered without quad enable");
   cont_quad_a: assert property ($rose(cont_read) |-> quad_lane_enable_bit)
      else $error("continuous read entered without quad enable");
   frame_end_a: assert property ($changed({qpi_mode, cont_read, four_byte_mode}) |-> link_cs_n)
      else $error("mode changed inside a frame");
   qe_write_a: assert property (reg_wr && reg_addr == ADDR_CTRL |=>
      quad_lane_enable_bit == $past(reg_wdata[0])) else $error("quad enable not written");
   reset_state_a: assert property ($fell(reset) |-> !qpi_mode && !cont_read &&
      !four_byte_mode && !quad_lane_enable_bit) else $error("bad state after reset");
   lanes_idle_a: assert property (four_data_lines_oe_n == 4'hF)
      else $error("data lanes driven");
   lanes_zero_a: assert property (four_data_lines_out == 4'h0)
      else $error("data lane outputs not zero");

   cover property ($rose(qpi_mode));
   cover property ($fell(cont_read));
   cover property ($fell(four_byte_mode));
endmodule // sfms_assertions

`default_nettype wire

// [sfms_host_model.sv]
// Host controller model driving link clock, chip select and data lanes.
// Assumes the bench calls its tasks; the link clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module sfms_host_model (
   output logic       link_sclk,
   output logic       link_cs_n,
   output logic [3:0] four_data_lines_in
);
   logic [3:0] last;

   initial begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      four_data_lines_in = 4'hA;
      last = 4'h5;
   end

   // Lanes change while the clock is low, so the device samples settled data.
   task automatic tick(input logic [3:0] d);
      four_data_lines_in = d;
      last = d;
      #400 link_sclk = 1'b1;
      #400 link_sclk = 1'b0;
   endtask

   task automatic open();
      #137 link_cs_n = 1'b0;
      #400;
   endtask

   // Released lanes show the inverse of the last value, never a stale copy.
   task automatic close();
      #400 link_cs_n = 1'b1;
      four_data_lines_in = ~last;
      #2000;
   endtask

   task automatic byte1(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) tick({~last[3:1], b[i]});
   endtask

   task automatic nibs(input logic [39:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) tick(v[4*i +: 4]);
   endtask
endmodule // sfms_host_model

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the flash mode-switch block and its checker.
// Assumes a 10 MHz clock; register reads are compared through a queue.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sfms_pkg::*;
   logic        clk = 1'b0;
   logic        reset, reg_wr, reg_rd, rd_d = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d, e, m;
   logic        link_sclk, link_cs_n, qpi_mode, cont_read, four_byte_mode, quad_en;
   logic [3:0]  lanes_in, lanes_out, lanes_oe_n;
   logic [31:0] exp_q[$], msk_q[$];
   int          num_errors = 0, checks_done = 0, seed;

   always #50 clk = ~clk;

   sfms_core uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_sclk(link_sclk),
      .link_cs_n(link_cs_n), .four_data_lines_in(lanes_in), .four_data_lines_out(lanes_out),
      .four_data_lines_oe_n(lanes_oe_n), .qpi_mode(qpi_mode), .cont_read(cont_read),
      .four_byte_mode(four_byte_mode), .quad_lane_enable_bit(quad_en));
   sfms_host_model u_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
      .four_data_lines_in(lanes_in));

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      exp_q.push_back(x); msk_q.push_back(k);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic cmd(input logic [7:0] b);
      u_host.open(); u_host.byte1(b); u_host.close();
   endtask

   // A continuous-read frame: optional opcode, address nibbles, mode byte, one data clock.
   task automatic cread(input bit opc, input int an, input logic [7:0] mode);
      u_host.open();
      if (opc) u_host.byte1(INS_QUAD_READ);
      u_host.nibs({8'h0, 32'($random(seed))}, an);
      u_host.nibs({32'h0, mode}, 2);
      u_host.nibs(40'h5, 1);
      u_host.close();
   endtask

   task automatic ffrun(input int n);
      u_host.open(); u_host.nibs('1, n); u_host.close();
   endtask

   always @(posedge clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         checks_done++;
         if ((reg_rdata & m) !== (e & m)) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rdata & m, e & m);
         end
      end
      rd_d <= reg_rd;
   end

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #3000000;
      num_errors++;
      end_of_test();
   end

   initial begin
      seed = 1884; reset = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0;
      reg_wr = 1'b0; reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_PDW_68, 32'hFF4DF619, '1);
      rd(ADDR_PDW_6C, 32'h85F950E9, '1);
      d = $random(seed);
      wr(ADDR_STAT, d);
      rd(ADDR_STAT, 32'h0, 32'hFF);
      wr({2'b10, d[5:0]}, d);
      rd({2'b10, d[13:8]}, 32'h0, '1);
      $display("test registers done");
      cmd(INS_QPI_ENTER);
      rd(ADDR_STAT, 32'h0, 32'h87);
      wr(ADDR_CTRL, d);
      rd(ADDR_STAT, {24'h0, d[0], 7'h0}, 32'h80);
      wr(ADDR_CTRL, 32'h1);
      cmd(INS_QPI_ENTER);
      rd(ADDR_STAT, 32'h81, 32'h87);
      // A quad read issued in four-wire mode carries its opcode as two nibbles.
      u_host.open();
      u_host.nibs({32'h0, INS_QUAD_READ}, 2);
      u_host.nibs(40'h0, 6);
      u_host.nibs(40'hA5, 2);
      u_host.nibs(40'h5, 1);
      u_host.close();
      rd(ADDR_STAT, 32'h83, 32'h87);
      cread(0, 6, MODE_EXIT);
      rd(ADDR_STAT, 32'h81, 32'h87);
      u_host.open(); u_host.nibs(40'hFF, 2); u_host.close();
      rd(ADDR_STAT, 32'h80, 32'h87);
      $display("test four-wire mode done");
      cmd(INS_4B_ENTER);
      rd(ADDR_STAT, 32'h84, 32'h87);
      cmd(INS_RST);
      rd(ADDR_STAT, 32'h84, 32'h87);
      cmd(INS_4B_EXIT);
      rd(ADDR_STAT, 32'h80, 32'h87);
      $display("test address mode done");
      cread(1, 6, {4'hA, d[19:16]});
      rd(ADDR_STAT, 32'h82, 32'h87);
      cread(0, 6, MODE_EXIT);
      rd(ADDR_STAT, 32'h80, 32'h87);
      cread(1, 6, 8'hA0);
      ffrun(8);
      rd(ADDR_STAT, 32'h80, 32'h87);
      cmd(INS_4B_ENTER);
      cread(1, 8, 8'hA3);
      rd(ADDR_STAT, 32'h86, 32'h87);
      ffrun(10);
      rd(ADDR_STAT, 32'h84, 32'h87);
      $display("test continuous read done");
      cmd(INS_WREN);
      rd(ADDR_STAT, 32'h08, 32'h08);
      u_host.open(); u_host.byte1(INS_WR_SR1); u_host.byte1(d[31:24]); u_host.close();
      rd(ADDR_STAT, {16'h0, d[31:24], 8'h0}, 32'hFF08);
      cmd(INS_VOL_WREN);
      u_host.open(); u_host.byte1(INS_WR_SR1); u_host.byte1(~d[31:24]); u_host.close();
      rd(ADDR_STAT, {16'h0, ~d[31:24], 8'h20}, 32'hFF20);
      $display("test status writes done");
      cmd(INS_RST_EN);
      cmd(INS_RST);
      rd(ADDR_STAT, {16'h0, d[31:24], 8'h80}, 32'hFF3F);
      cmd(INS_WREN);
      u_host.open();
      u_host.byte1(INS_WR_SR2);
      u_host.byte1(d[7:0]);
      u_host.close();
      rd(ADDR_STAT, {24'h0, d[1], 7'h0}, 32'h88);
      $display("test soft reset done");
      repeat (3) @(posedge clk);
      end_of_test();
   end
endmodule // testbench

bind sfms_core sfms_assertions u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .link_sclk(link_sclk), .link_cs_n(link_cs_n), .four_data_lines_in(four_data_lines_in),
   .four_data_lines_out(four_data_lines_out), .four_data_lines_oe_n(four_data_lines_oe_n),
   .qpi_mode(qpi_mode), .cont_read(cont_read), .four_byte_mode(four_byte_mode),
   .quad_lane_enable_bit(quad_lane_enable_bit));

`default_nettype wire
